// ===== hdl/tap_defines.svh
// Constants for the test access port controller
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH

`define TAP_IR_WIDTH     5
`define TAP_IDCODE_INSTR 5'h01
`define TAP_BYPASS_INSTR 5'h1F
`define TAP_IR_CAPTURE   5'h01
`define TAP_DR_WIDTH     32
`define TAP_SYNC_STAGES  2

`endif

// ===== hdl/tap_pkg.sv
// Types for the test access port controller
package tap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR_SCAN,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR_SCAN,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_e;

endpackage

// ===== hdl/tap_controller.sv
// Sixteen-state test access port controller, oversampling the probe pins
//
// Functional notes
// RL1 - Sample mode and data on test clock rise; drive data out on fall.
// RL2 - Low test reset forces reset state and loads identify instruction.
// RL3 - Reset state resets only controller and instruction, nothing else.
// RL4 - Five rising edges with mode high always reach reset state.
// RL5 - In reset state test logic is off and bypass path is used.
// RL6 - Reset state with mode low moves to idle.
// RL7 - Idle holds on low, goes to select data scan on high.
// RL8 - Select data scan: low to capture data, high to select instruction.
// RL9 - Select instruction scan: low to capture, high back to reset.
// RL10 - Capture data loads selected register; low to shift, high to exit1.
// RL11 - Shift data moves one bit per rise; high leaves to exit1.
// RL12 - Data exit1: low to pause, high to update.
// RL13 - Data pause holds registers; high goes to exit2.
// RL14 - Data exit2: low back to shift, high to update.
// RL15 - Update data applies shifted value; low idle, high select data.
// RL16 - Capture instruction loads pattern 00001 into instruction shifter.
// RL17 - Shift instruction moves one stage per rise; high leaves to exit1.
// RL18 - Instruction exit1, pause, exit2 mirror the data side.
// RL19 - Update instruction makes new instruction active; low idle, high select.
// RL20 - Instruction changes only in update instruction and reset.
// RL21 - Shadow outputs hold during capture and shift; load only on update.
// RL22 - Probe starts scans from idle and may park in pause states.
// RL23 - Data output disabled whenever nothing is being shifted out.
// RL24 - Test reset is asynchronous and never resets processor logic.
// RL25 - Five bit instruction; undecoded codes act as bypass. The path here follows dr_select_in, not the instruction.
`include "tap_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tap_controller
  import tap_pkg::*;
#(
  parameter int DR_WIDTH = `TAP_DR_WIDTH
) (
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     tck_in,
  input  wire logic                     tms_in,
  input  wire logic                     tdi_in,
  input  wire logic                     trst_n_in,
  input  wire logic                     dr_select_in,
  input  wire logic [DR_WIDTH-1:0]      dr_capture_in,
  output logic                          tdo_out,
  output logic                          tdo_oe_out,
  output tap_state_e                    tap_state_out,
  output logic [`TAP_IR_WIDTH-1:0]      instruction_out,
  output logic                          test_logic_en_out,
  output logic                          capture_dr_out,
  output logic                          update_dr_out,
  output logic [DR_WIDTH-1:0]           dr_shadow_out
);

  // Pin synchronisers: tck, tms, tdi, trst_n
  logic [3:0]                  sync_a;
  logic [3:0]                  sync_b;
  logic                        tck_last;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_a   <= 4'h0;
      sync_b   <= 4'h0;
      tck_last <= 1'b0;
    end else begin
      sync_a   <= {trst_n_in, tdi_in, tms_in, tck_in};
      sync_b   <= sync_a;
      tck_last <= sync_b[0];
    end
  end

  // Decoded pin levels and test clock edges
  wire tck_s     = sync_b[0];
  wire tms_s     = sync_b[1];
  wire tdi_s     = sync_b[2];
  wire trst_n_s  = sync_b[3];
  wire tck_rise  = tck_s & ~tck_last;  // see RL1
  wire tck_fall  = ~tck_s & tck_last;  // see RL1

  tap_state_e                  state;
  tap_state_e                  next_state;
  logic [`TAP_IR_WIDTH-1:0]    ir_shift;
  logic [`TAP_IR_WIDTH-1:0]    instruction;
  logic [DR_WIDTH-1:0]         dr_shift;
  logic                        bypass_bit;

  // State transitions on a sampled mode level
  always_comb begin
    case (state)
      TEST_LOGIC_RESET:
        next_state = tms_s ? TEST_LOGIC_RESET : RUN_TEST_IDLE; // see RL5 RL6
      RUN_TEST_IDLE:
        next_state = tms_s ? SELECT_DR_SCAN : RUN_TEST_IDLE;   // see RL7
      SELECT_DR_SCAN:
        next_state = tms_s ? SELECT_IR_SCAN : CAPTURE_DR;      // see RL8
      CAPTURE_DR:
        next_state = tms_s ? EXIT1_DR : SHIFT_DR;              // see RL10
      SHIFT_DR:
        next_state = tms_s ? EXIT1_DR : SHIFT_DR;              // see RL11
      EXIT1_DR:
        next_state = tms_s ? UPDATE_DR : PAUSE_DR;             // see RL12
      PAUSE_DR:
        next_state = tms_s ? EXIT2_DR : PAUSE_DR;              // see RL13
      EXIT2_DR:
        next_state = tms_s ? UPDATE_DR : SHIFT_DR;             // see RL14
      UPDATE_DR:
        next_state = tms_s ? SELECT_DR_SCAN : RUN_TEST_IDLE;   // see RL15
      SELECT_IR_SCAN:
        next_state = tms_s ? TEST_LOGIC_RESET : CAPTURE_IR;    // see RL9
      CAPTURE_IR:
        next_state = tms_s ? EXIT1_IR : SHIFT_IR;              // see RL16
      SHIFT_IR:
        next_state = tms_s ? EXIT1_IR : SHIFT_IR;              // see RL17
      EXIT1_IR:
        next_state = tms_s ? UPDATE_IR : PAUSE_IR;             // see RL18
      PAUSE_IR:
        next_state = tms_s ? EXIT2_IR : PAUSE_IR;              // see RL18
      EXIT2_IR:
        next_state = tms_s ? UPDATE_IR : SHIFT_IR;             // see RL18
      UPDATE_IR:
        next_state = tms_s ? SELECT_DR_SCAN : RUN_TEST_IDLE;   // see RL19
      default:
        next_state = TEST_LOGIC_RESET;
    endcase
  end

  // Path selection; bypass unless dr_select_in is high outside reset
  wire in_reset   = (state == TEST_LOGIC_RESET);
  wire use_dr     = dr_select_in & ~in_reset;         // see RL5 RL25
  wire dr_serial  = use_dr ? dr_shift[0] : bypass_bit;
  wire shifting   = (state == SHIFT_DR) | (state == SHIFT_IR);
  wire next_tdo   = (state == SHIFT_IR) ? ir_shift[0] : dr_serial;

  // Controller state; any path of five mode-high rises ends in reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= TEST_LOGIC_RESET;
    end else if (!trst_n_s) begin
      state <= TEST_LOGIC_RESET;                      // see RL2 RL24
    end else if (tck_rise) begin
      state <= next_state;                            // see RL4
    end
  end

  // Instruction shifter and active instruction
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ir_shift    <= `TAP_IR_CAPTURE;
      instruction <= `TAP_IDCODE_INSTR;
    end else if (!trst_n_s) begin
      instruction <= `TAP_IDCODE_INSTR;               // see RL2 RL3
    end else if (tck_rise) begin
      case (state)
        TEST_LOGIC_RESET: instruction <= `TAP_IDCODE_INSTR; // see RL20
        CAPTURE_IR: ir_shift <= `TAP_IR_CAPTURE;      // see RL16
        SHIFT_IR: ir_shift <= {tdi_s, ir_shift[`TAP_IR_WIDTH-1:1]}; // see RL17
        UPDATE_IR: instruction <= ir_shift;           // see RL19 RL20
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  // Data path: bypass bit, shift path and shadow latch
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bypass_bit    <= 1'b0;
      dr_shift      <= '0;
      dr_shadow_out <= '0;
    end else if (tck_rise) begin
      case (state)
        CAPTURE_DR: begin
          bypass_bit <= 1'b0;
          if (use_dr) begin
            dr_shift <= dr_capture_in;                // see RL10
          end
        end
        SHIFT_DR: begin
          bypass_bit <= tdi_s;                        // see RL11
          if (use_dr) begin
            dr_shift <= {tdi_s, dr_shift[DR_WIDTH-1:1]};
          end
        end
        UPDATE_DR: begin
          if (use_dr) begin
            dr_shadow_out <= dr_shift;                // see RL15 RL21
          end
        end
        default: dr_shift <= dr_shift;                // see RL13
      endcase
    end
  end

  // Serial output changes on the falling test clock edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (!trst_n_s) begin
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out    <= shifting ? next_tdo : 1'b0;       // see RL1
      tdo_oe_out <= shifting;                         // see RL23
    end
  end

  // Registered status and one-cycle phase strobes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tap_state_out     <= TEST_LOGIC_RESET;
      instruction_out   <= `TAP_IDCODE_INSTR;
      test_logic_en_out <= 1'b0;
      capture_dr_out    <= 1'b0;
      update_dr_out     <= 1'b0;
    end else begin
      tap_state_out     <= state;
      instruction_out   <= in_reset ? `TAP_BYPASS_INSTR : instruction; // see RL5
      test_logic_en_out <= ~in_reset;                 // see RL5
      capture_dr_out    <= tck_rise & (state == CAPTURE_DR) & use_dr;
      update_dr_out     <= tck_rise & (state == UPDATE_DR) & use_dr; // see RL21
    end
  end

endmodule

`default_nettype wire

// ===== tb/tap_probe.sv
// Debug probe model driving the test pins from the system clock
`timescale 1ns/100ps
`default_nettype none
module tap_probe (
  input  wire logic clk_in,
  input  wire logic tdo_in,
  output var logic  tck_out,
  output var logic  tms_out,
  output var logic  tdi_out,
  output var logic  trst_n_out
);
  // Test clock stands low between frames, test reset released
  initial {tck_out, tms_out, tdi_out, trst_n_out} = 4'b0101;
  // One test clock: mode and data set while low, output read at rise
  task automatic step(input logic m, input logic d, output logic q);
    tms_out <= m;
    tdi_out <= d;
    repeat (10) @(posedge clk_in);
    tck_out <= 1'b1;
    q = tdo_in;
    repeat (10) @(posedge clk_in);
    tck_out <= 1'b0;
  endtask
  // Test reset pulse, long enough to pass the pin synchroniser
  task automatic trst();
    trst_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    trst_n_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/tap_controller_props.sv
// Port assertions for the test access port controller
`include "tap_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tap_controller_props
  import tap_pkg::*;
#(parameter int DR_WIDTH = 32) (
  input wire logic                clk_in,
  input wire logic                reset_in,
  input wire logic                trst_n_in,
  input wire logic                tdo_oe_out,
  input wire tap_state_e          tap_state_out,
  input wire logic [4:0]          instruction_out,
  input wire logic                test_logic_en_out,
  input wire logic                capture_dr_out,
  input wire logic                update_dr_out,
  input wire logic [DR_WIDTH-1:0] dr_shadow_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // State sequencing, instruction, output enable, strobes and shadow
  tlr_bypass_a: assert property (
    (trst_n_in && tap_state_out == TEST_LOGIC_RESET) [*5] |->
    !test_logic_en_out && instruction_out == `TAP_BYPASS_INSTR)
    else $error("reset state not showing bypass");
  trst_force_a: assert property (
    !trst_n_in [*5] |-> tap_state_out == TEST_LOGIC_RESET)
    else $error("test reset did not force reset state");
  oe_shift_a: assert property (
    tdo_oe_out |-> tap_state_out inside
    {SHIFT_DR, EXIT1_DR, SHIFT_IR, EXIT1_IR})
    else $error("data output enabled outside a shift");
  instr_hold_a: assert property (
    $changed(instruction_out) |-> !trst_n_in ||
    tap_state_out == TEST_LOGIC_RESET ||
    $past(tap_state_out) inside {UPDATE_IR, TEST_LOGIC_RESET})
    else $error("instruction changed outside update");
  idle_exit_a: assert property (
    tap_state_out == RUN_TEST_IDLE ##1 tap_state_out != RUN_TEST_IDLE
    |-> tap_state_out inside {SELECT_DR_SCAN, TEST_LOGIC_RESET})
    else $error("bad exit from idle");
  cap_pulse_a: assert property (
    capture_dr_out |-> tap_state_out == CAPTURE_DR ##1 !capture_dr_out)
    else $error("capture strobe misplaced");
  upd_pulse_a: assert property (
    update_dr_out |-> tap_state_out == UPDATE_DR ##1 !update_dr_out)
    else $error("update strobe misplaced");
  shadow_hold_a: assert property (
    $changed(dr_shadow_out) |-> update_dr_out || $past(update_dr_out))
    else $error("shadow changed without update");
  // Main scenarios reached
  cover property (update_dr_out);
  cover property (tap_state_out == PAUSE_DR ##1 tap_state_out == EXIT2_DR);
  cover property (tap_state_out == UPDATE_IR ##1 tap_state_out != UPDATE_IR);
endmodule
bind tap_controller tap_controller_props #(.DR_WIDTH(DR_WIDTH)) props_i (.*);
`default_nettype wire

// ===== tb/test_tap_controller.sv
// Self-checking bench for the test access port controller
`include "tap_defines.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_tap_controller
  import tap_pkg::*;
;
  logic       clk_in = 0, reset_in = 1, dr_select_in = 0;
  logic       tck, tms, tdi, trst_n, tdo_out, tdo_oe_out;
  logic       test_logic_en_out, capture_dr_out, update_dr_out;
  logic [7:0] dr_capture_in = 8'h96, dr_shadow_out;
  logic [4:0] instruction_out;
  tap_state_e tap_state_out;
  logic [16:0] q;
  int         error_cnt = 0, checked = 0;
  always #4 clk_in = ~clk_in;
  tap_controller #(.DR_WIDTH(8)) tap_controller_i (.clk_in, .reset_in,
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n),
    .dr_select_in, .dr_capture_in, .tdo_out, .tdo_oe_out, .tap_state_out,
    .instruction_out, .test_logic_en_out, .capture_dr_out, .update_dr_out,
    .dr_shadow_out);
  tap_probe tap_probe_i (.clk_in, .tdo_in(tdo_out), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n));
  // Clock n test cycles, mode and data taken lowest bit first
  task automatic scan(input int n, input logic [16:0] m, input logic [16:0] d);
    for (int i = 0; i < n; i++) tap_probe_i.step(m[i], d[i], q[i]);
  endtask
  // Instruction scan from idle, reading back the captured pattern
  task automatic t_ir(input logic [4:0] c);
    scan(11, 17'h00303, {8'h00, c, 4'h0});
    `CHK(q[8:4], `TAP_IR_CAPTURE)
    `CHK(instruction_out, c)
  endtask
  // Data scan parked in pause halfway, then updated
  task automatic t_dr();
    dr_select_in <= 1'b1;
    scan(17, 17'h0C241, 17'h02850);
    `CHK({q[14:11], q[6:3]}, 8'h96)
    `CHK(dr_shadow_out, 8'h5A)
  endtask
  // Unselected data scan goes through the one-bit bypass path
  task automatic t_byp();
    dr_select_in <= 1'b0;
    scan(7, 17'h00031, 17'h00008);
    `CHK(q[4:3], 2'b10)
    `CHK(dr_shadow_out, 8'h5A)
  endtask
  // Test reset from idle leaves the data shadow alone
  task automatic t_trst();
    tap_probe_i.trst();
    repeat (4) @(posedge clk_in);
    `CHK(tap_state_out, TEST_LOGIC_RESET)
    `CHK(dr_shadow_out, 8'h5A)
    scan(1, 17'h0, 17'h0);
    `CHK(instruction_out, `TAP_IDCODE_INSTR)
  endtask
  // Five high mode bits from mid-shift reach the reset state
  task automatic t_five();
    scan(8, 17'h000F9, 17'h0);
    `CHK(tap_state_out, TEST_LOGIC_RESET)
    `CHK(instruction_out, `TAP_BYPASS_INSTR)
    `CHK(test_logic_en_out, 1'b0)
  endtask
  // Counts and verdict
  task automatic report_and_stop();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK(instruction_out, `TAP_BYPASS_INSTR)
    scan(1, 17'h0, 17'h0);
    `CHK(tap_state_out, RUN_TEST_IDLE)
    t_ir(5'h0A);
    t_ir(5'h15);
    t_dr();
    t_byp();
    t_trst();
    t_five();
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
